//--- shared/dost_params.svh
// constants for the deserializer output-state and link self-test block
// Behaviour
// - power-up starts lock; lock low or released
// - lock output high once lock completes
// - power-down releases every output
// - drive-off, state-select 0: outputs driven low
// - drive-off, state-select 1: outputs released
// - no lock: outputs low, clock optional oscillator
// - no activity: lock low, pass held
// - locked, enabled, state-select 1: all outputs valid
// - self-test configured by pins or register
// - enable pin high enters self-test
// - pins pick pixel clock or oscillator
// - register bits pick clock per mode
// - errored frame pulses pass low briefly
// - run result shown one pixel cycle
// - readable error-frame count, kept until restart or power-down
// - lock in self-test raises pass, checks
// - self-test commands remote serializer pattern
// - enable pin low stops checking, normal
`ifndef DOST_PARAMS_SVH
`define DOST_PARAMS_SVH

`define DOST_ADDR_W          8
`define DOST_OFF_CTRL        8'h24
`define DOST_OFF_ERRCNT      8'h25
`define DOST_CTRL_RESET      8'h00
`define DOST_CTRL_EN_BIT     0
`define DOST_CTRL_CLK_LO     1
`define DOST_CTRL_CLK_HI     2
`define DOST_CTRL_REGCFG_BIT 3
`define DOST_CTRL_OSC_BIT    4
`define DOST_RESULT_CYCLES   2'h2

`endif

//--- shared/dost_pkg.sv
// types for the deserializer output-state and link self-test block
package dost_pkg;

	typedef enum logic [1:0] {
		DOST_IDLE = 2'h0,
		DOST_WAIT = 2'h1,
		DOST_RUN  = 2'h3,
		DOST_DONE = 2'h2
	} dost_state_t;

	typedef enum logic [1:0] {
		DOST_MODE_10B  = 2'h0,
		DOST_MODE_12HF = 2'h1,
		DOST_MODE_12LF = 2'h2
	} dost_mode_t;

	typedef enum logic [2:0] {
		DOST_CLK_PCLK   = 3'h0,
		DOST_CLK_OSC100 = 3'h1,
		DOST_CLK_OSC75  = 3'h2,
		DOST_CLK_OSC50  = 3'h3,
		DOST_CLK_OSC37  = 3'h4,
		DOST_CLK_OSC25  = 3'h5
	} dost_clk_t;

endpackage

//--- hw/dost_err_count.sv
// saturating error-frame counter for the link self-test
`timescale 1ns/100ps
module dost_err_count #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic         clk_en,
	// control
	input  wire logic         clr,
	input  wire logic         inc,
	// count
	output logic [W-1:0]      count
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} dost_cnt_s_t;

	dost_cnt_s_t s_q;
	dost_cnt_s_t s_d;

	always_comb begin
		s_d = s_q;
		if (clr) begin
			s_d.cnt = '0;
		end else if (inc && (s_q.cnt != {W{1'b1}})) begin
			s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign count = s_q.cnt;
endmodule

//--- hw/dost_top.sv
// deserializer output-state control and at-speed link self-test checker
`timescale 1ns/100ps
`include "dost_params.svh"
module dost_top #(
	parameter int DATA_W = 12,
	parameter int GPIO_W = 4,
	parameter int CNT_W  = 8
) (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	input  wire logic                    clk_en,
	// output control pins
	input  wire logic                    power_down_n,
	input  wire logic                    output_drive_enable,
	input  wire logic                    output_state_select,
	input  wire dost_pkg::dost_mode_t    mode,
	// recovery front end
	input  wire logic                    serial_active,
	input  wire logic                    recovery_lock_done,
	input  wire logic [DATA_W-1:0]       rx_data,
	input  wire logic [GPIO_W-1:0]       rx_gpio,
	// self-test inputs
	input  wire logic                    selftest_enable_pin,
	input  wire logic [1:0]              selftest_clk_pins,
	input  wire logic                    remote_in_selftest,
	input  wire logic                    frame_done,
	input  wire logic                    frame_err,
	// register port
	input  wire logic [`DOST_ADDR_W-1:0] reg_addr,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [7:0]              reg_wdata,
	output logic [7:0]                   reg_rdata,
	// back channel and clock selection
	output logic                         remote_selftest_start,
	output dost_pkg::dost_clk_t          selftest_clk_sel,
	output logic                         selftest_active,
	// pins with their enables; gpio_o shares data_oe with data_o
	output logic                         lock_o,
	output logic                         lock_oe,
	output logic                         pass_o,
	output logic                         pass_oe,
	output logic [DATA_W-1:0]            data_o,
	output logic [GPIO_W-1:0]            gpio_o,
	output logic                         data_oe,
	output logic                         pclk_o,
	output logic                         pclk_oe
);
	import dost_pkg::*;

	typedef struct packed {
		dost_state_t        st;
		logic [1:0]         hold;
		logic               result;
		logic [7:0]         ctrl;
		logic [7:0]         rdata;
		logic               lock;
		logic               acq;
		logic               pclk_ph;
		logic               pass_int;
		logic               lock_o;
		logic               lock_oe;
		logic               pass_o;
		logic               pass_oe;
		logic [DATA_W-1:0]  data_o;
		logic [GPIO_W-1:0]  gpio_o;
		logic               data_oe;
		logic               pclk_o;
		logic               pclk_oe;
		logic               remote;
		dost_clk_t          clk_sel;
	} dost_s_t;

	dost_s_t            s_q;
	dost_s_t            s_d;
	logic [CNT_W-1:0]   err_count;
	logic               cnt_clr;
	logic               cnt_inc;
	logic               st_en;
	logic [1:0]         reg_clk;

	dost_err_count #(
		.W      (CNT_W)
	) i_dost_err_count (
		.clock  (clock),
		.rst_b  (rst_b),
		.clk_en (clk_en),
		.clr    (cnt_clr),
		.inc    (cnt_inc),
		.count  (err_count)
	);

	assign st_en = s_q.ctrl[`DOST_CTRL_REGCFG_BIT] ?
		s_q.ctrl[`DOST_CTRL_EN_BIT] : selftest_enable_pin;
	assign reg_clk = s_q.ctrl[`DOST_CTRL_CLK_HI:`DOST_CTRL_CLK_LO];

	assign cnt_clr = !power_down_n ||
		(s_q.st == DOST_IDLE && st_en);
	assign cnt_inc = power_down_n && s_q.st == DOST_RUN && st_en &&
		frame_done && frame_err;

	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`DOST_OFF_CTRL:   s_d.rdata = s_q.ctrl;
				`DOST_OFF_ERRCNT: s_d.rdata = 8'(err_count);
				default:          s_d.rdata = 8'h00;
			endcase
		end
		if (reg_wr && reg_addr == `DOST_OFF_CTRL) begin
			s_d.ctrl = reg_wdata;
		end
		s_d.pclk_ph = ~s_q.pclk_ph;

		if (!serial_active) begin
			s_d.lock = 1'b0;
		end else if (recovery_lock_done) begin
			s_d.lock = 1'b1;
			s_d.acq = 1'b0;
		end

		if (s_q.ctrl[`DOST_CTRL_REGCFG_BIT]) begin
			case (reg_clk)
				2'h1: begin
					case (mode)
						DOST_MODE_10B:  s_d.clk_sel = DOST_CLK_OSC100;
						DOST_MODE_12HF: s_d.clk_sel = DOST_CLK_OSC75;
						default:        s_d.clk_sel = DOST_CLK_OSC50;
					endcase
				end
				2'h2: begin
					case (mode)
						DOST_MODE_10B:  s_d.clk_sel = DOST_CLK_OSC50;
						DOST_MODE_12HF: s_d.clk_sel = DOST_CLK_OSC37;
						default:        s_d.clk_sel = DOST_CLK_OSC25;
					endcase
				end
				// reserved code falls back to pixel clock
				default: s_d.clk_sel = DOST_CLK_PCLK;
			endcase
		end else begin
			case (selftest_clk_pins)
				2'h1:    s_d.clk_sel = DOST_CLK_OSC50;
				2'h2:    s_d.clk_sel = DOST_CLK_OSC25;
				default: s_d.clk_sel = DOST_CLK_PCLK;
			endcase
		end

		case (s_q.st)
			DOST_IDLE: begin
				s_d.pass_int = 1'b0;
				if (st_en) begin
					s_d.st = DOST_WAIT;
					s_d.result = 1'b1;
				end
			end
			DOST_WAIT: begin
				if (!st_en) begin
					s_d.st = DOST_IDLE;
				end else if (s_q.lock && remote_in_selftest) begin
					s_d.st = DOST_RUN;
					s_d.pass_int = 1'b1;
				end
			end
			DOST_RUN: begin
				s_d.pass_int = 1'b1;
				if (!st_en) begin
					s_d.st = DOST_DONE;
					s_d.hold = `DOST_RESULT_CYCLES;
					s_d.pass_int = s_q.result;
				// one low clock is half a pixel period
				end else if (frame_done && frame_err) begin
					s_d.pass_int = 1'b0;
					s_d.result = 1'b0;
				end
			end
			DOST_DONE: begin
				// result for one pixel period only
				s_d.pass_int = s_q.result;
				s_d.hold = s_q.hold - 2'h1;
				if (s_q.hold == 2'h1) begin
					s_d.st = DOST_IDLE;
					s_d.pass_int = 1'b0;
				end
			end
			default: s_d.st = DOST_IDLE;
		endcase

		// back channel asks for the pattern
		s_d.remote = (s_d.st == DOST_WAIT) || (s_d.st == DOST_RUN);

		// lock released while acquiring with drive off
		s_d.lock_o = s_d.lock;
		s_d.lock_oe = !(s_d.acq && !output_drive_enable);
		if (!output_drive_enable) begin
			s_d.pass_o = 1'b0;
			s_d.data_o = '0;
			s_d.gpio_o = '0;
			s_d.pclk_o = 1'b0;
			s_d.pass_oe = !output_state_select;
			s_d.data_oe = !output_state_select;
			s_d.pclk_oe = !output_state_select;
		end else begin
			s_d.pass_oe = 1'b1;
			s_d.data_oe = 1'b1;
			s_d.pclk_oe = 1'b1;
			s_d.data_o = '0;
			s_d.gpio_o = '0;
			s_d.pclk_o = 1'b0;
			if (!output_state_select) begin
				s_d.pass_o = 1'b0;
				if (!s_d.lock && s_q.ctrl[`DOST_CTRL_OSC_BIT]) begin
					s_d.pclk_o = s_q.pclk_ph;
				end
			end else if (!s_d.lock) begin
				s_d.pass_o = s_q.pass_o;
			end else begin
				s_d.pass_o = s_d.pass_int;
				s_d.data_o = rx_data;
				s_d.gpio_o = rx_gpio;
				s_d.pclk_o = s_q.pclk_ph;
			end
		end

		// power-down acts as reset and releases pins
		if (!power_down_n) begin
			s_d = '0;
			s_d.acq = 1'b1;
			s_d.ctrl = `DOST_CTRL_RESET;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.acq <= 1'b1;
			s_q.ctrl <= `DOST_CTRL_RESET;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign remote_selftest_start = s_q.remote;
	assign selftest_clk_sel = s_q.clk_sel;
	assign selftest_active = s_q.st == DOST_RUN;
	assign lock_o = s_q.lock_o;
	assign lock_oe = s_q.lock_oe;
	assign pass_o = s_q.pass_o;
	assign pass_oe = s_q.pass_oe;
	assign data_o = s_q.data_o;
	assign gpio_o = s_q.gpio_o;
	assign data_oe = s_q.data_oe;
	assign pclk_o = s_q.pclk_o;
	assign pclk_oe = s_q.pclk_oe;

	pd_release_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && !power_down_n) |=>
			!lock_oe && !pass_oe && !data_oe && !pclk_oe)
		else $error("outputs driven during power-down");

	lock_rise_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && serial_active &&
			recovery_lock_done) |=> lock_o && lock_oe)
		else $error("lock not raised after lock done");

	drive_low_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && !output_drive_enable &&
			!output_state_select) |=>
			pass_oe && !pass_o && data_oe && data_o == '0 && !pclk_o)
		else $error("drive-off low state wrong");

	drive_float_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && !output_drive_enable &&
			output_state_select) |=> !pass_oe && !data_oe && !pclk_oe)
		else $error("drive-off outputs not released");

	idle_hold_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && output_drive_enable &&
			output_state_select && !serial_active) |=>
			!lock_o && pass_o == $past(pass_o) && data_o == '0)
		else $error("static link state wrong");

	err_pulse_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && st_en && s_q.st == DOST_RUN &&
			frame_done && frame_err) |=> !s_q.pass_int && !s_q.result)
		else $error("errored frame gave no pass pulse");

	result_span_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && s_q.st == DOST_RUN && !st_en)
			##1 clk_en [*2] |=> s_q.st == DOST_IDLE && !s_q.pass_int)
		else $error("result not limited to one pixel period");

	session_clear_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && cnt_clr) |=> err_count == '0)
		else $error("error count not cleared at session start");

	remote_cmd_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(s_q.st == DOST_WAIT || s_q.st == DOST_RUN) |->
			remote_selftest_start)
		else $error("remote serializer not commanded");

	run_entry_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && s_q.st == DOST_WAIT && st_en &&
			s_q.lock && remote_in_selftest) |=>
			s_q.st == DOST_RUN && s_q.pass_int)
		else $error("self-test run not started on lock");

	stop_check_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && s_q.st == DOST_RUN && !st_en) |=>
			s_q.st == DOST_DONE && !remote_selftest_start)
		else $error("checker kept running after disable");

	pd_count_clear_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && !power_down_n) |=> err_count == '0)
		else $error("error count kept through power-down");

	clock_low_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && output_drive_enable &&
			!output_state_select && !s_q.ctrl[`DOST_CTRL_OSC_BIT]) |=>
			pclk_oe && !pclk_o && !pass_o)
		else $error("clock output not held low");

	pclk_code_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(clk_en && power_down_n && s_q.ctrl[`DOST_CTRL_REGCFG_BIT] &&
			reg_clk == 2'h0) |=> selftest_clk_sel == DOST_CLK_PCLK)
		else $error("register clock code zero not pixel clock");
endmodule

//--- verif/dost_remote_ser.sv
// behavioural remote serializer that sends the self-test pattern
`timescale 1ns/100ps
module dost_remote_ser (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// back channel and test control
	input  wire logic       start,
	input  wire logic [3:0] err_frames,
	// forward channel frames
	output logic            in_selftest,
	output logic            frame_done,
	output logic            frame_err
);
	logic [3:0] gap_q;
	logic [3:0] errs_q;
	logic       frame;

	assign frame = (gap_q == 4'hb);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			in_selftest <= 1'b0;
			frame_done  <= 1'b0;
			frame_err   <= 1'b0;
			gap_q       <= 4'h0;
			errs_q      <= 4'h0;
		end else if (!start) begin
			in_selftest <= 1'b0;
			frame_done  <= 1'b0;
			frame_err   <= ~frame_err;
			gap_q       <= 4'h0;
			errs_q      <= err_frames;
		end else begin
			in_selftest <= 1'b1;
			// first frame after a settling gap, then one every four cycles
			gap_q       <= frame ? 4'h8 : gap_q + 4'h1;
			frame_done  <= frame;
			// qualifier is junk between frames, as on the real link
			frame_err   <= frame ? (errs_q != 4'h0) : ~frame_err;
			if (frame && errs_q != 4'h0) begin
				errs_q <= errs_q - 4'h1;
			end
		end
	end
endmodule

//--- verif/test_deser_output_state_and_link_selftest.sv
// self-checking bench for output states and link self-test
`timescale 1ns/100ps
module test_deser_output_state_and_link_selftest;
	import dost_pkg::*;
	logic clock = 0, rst_b = 0, clk_en = 1, power_down_n = 0;
	logic output_drive_enable = 0, output_state_select = 0;
	dost_mode_t mode = DOST_MODE_10B;
	logic serial_active = 0, recovery_lock_done = 0;
	logic [11:0] rx_data = 12'h5a3;
	logic [3:0] rx_gpio = 4'h9, err_frames = 4'h0;
	logic selftest_enable_pin = 0, remote_in_selftest;
	logic [1:0] selftest_clk_pins = 2'h0;
	logic frame_done, frame_err, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic remote_selftest_start, selftest_active;
	dost_clk_t selftest_clk_sel;
	logic lock_o, lock_oe, pass_o, pass_oe, data_oe, pclk_o, pclk_oe;
	logic [11:0] data_o;
	logic [3:0] gpio_o;
	int failures = 0, total_checks = 0;

	dost_top i_dost_top (.clock, .rst_b, .clk_en, .power_down_n,
		.output_drive_enable, .output_state_select, .mode, .serial_active,
		.recovery_lock_done, .rx_data, .rx_gpio,
		.selftest_enable_pin,
		.selftest_clk_pins, .remote_in_selftest, .frame_done, .frame_err,
		.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.remote_selftest_start, .selftest_clk_sel, .selftest_active,
		.lock_o, .lock_oe, .pass_o, .pass_oe, .data_o, .gpio_o, .data_oe,
		.pclk_o, .pclk_oe);
	dost_remote_ser i_dost_remote_ser (.clock, .rst_b,
		.start(remote_selftest_start), .err_frames,
		.in_selftest(remote_in_selftest), .frame_done, .frame_err);

	always #10 clock = ~clock;

	task automatic chk(string n, logic [11:0] e, logic [11:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic pins(logic pd, logic oe, logic os, logic act);
		@(posedge clock);
		power_down_n <= pd;
		output_drive_enable <= oe;
		output_state_select <= os;
		serial_active <= act;
		recovery_lock_done <= act;
		tick(3);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge clock);
		reg_wr <= 0;
		tick(2);
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clock);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask

	task automatic t_states;
		logic p0;
		pins(0, 1, 1, 1);
		chk("oe all", 0, {lock_oe, pass_oe, data_oe, pclk_oe});
		pins(1, 0, 0, 0);
		chk("lock oe", 0, lock_oe);
		chk("low pins", 12'h008, {pass_oe, pass_o, data_o[0], pclk_o});
		pins(1, 0, 0, 1);
		chk("lock", 3, {lock_oe, lock_o});
		pins(1, 0, 1, 1);
		chk("released", 1, {pass_oe, data_oe, pclk_oe, lock_o});
		pins(1, 1, 0, 1);
		chk("oen1 oss0", 12'h0f0, {lock_o, pass_oe, data_oe, pclk_oe,
			pass_o, pclk_o, |data_o, |gpio_o});
		pins(1, 1, 1, 1);
		chk("data", rx_data, data_o);
		chk("gpio", rx_gpio, gpio_o);
		p0 = pclk_o;
		tick(1);
		chk("pclk toggle", 1, p0 ^ pclk_o);
		// enable low must stop the toggling clock
		@(posedge clock);
		clk_en <= 0;
		tick(1);
		p0 = pclk_o;
		tick(1);
		chk("frozen", p0, pclk_o);
		@(posedge clock);
		clk_en <= 1;
		pins(1, 1, 1, 0);
		chk("static", 0, {lock_o, |data_o, pclk_o});
		pins(1, 1, 0, 0);
		chk("no osc", 0, {lock_o, !pclk_oe, pclk_o});
		wr(8'h24, 8'h10);
		p0 = pclk_o;
		tick(1);
		chk("osc", 1, p0 ^ pclk_o);
		wr(8'h24, 8'h00);
		pins(1, 1, 1, 1);
		$display("test states done");
	endtask

	task automatic t_clksel;
		dost_clk_t pe[3] = '{DOST_CLK_PCLK, DOST_CLK_OSC50, DOST_CLK_OSC25};
		dost_clk_t re[3] = '{DOST_CLK_OSC100, DOST_CLK_OSC75, DOST_CLK_OSC50};
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			selftest_clk_pins <= 2'(i);
			tick(3);
			chk("pin clk", pe[i], selftest_clk_sel);
		end
		wr(8'h24, 8'h0a);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			mode <= dost_mode_t'(i);
			tick(3);
			chk("reg clk", re[i], selftest_clk_sel);
		end
		rd(8'h24, d);
		chk("ctrl rd", 8'h0a, d);
		wr(8'h24, 8'h0c);
		chk("reg clk 10", DOST_CLK_OSC25, selftest_clk_sel);
		wr(8'h24, 8'h0e);
		chk("reg clk 11", DOST_CLK_PCLK, selftest_clk_sel);
		wr(8'h25, 8'h55);
		rd(8'h25, d);
		chk("count ro", 0, d);
		rd(8'h33, d);
		chk("unmapped", 0, d);
		wr(8'h24, 8'h09);
		chk("reg enable", 1, remote_selftest_start);
		wr(8'h24, 8'h00);
		tick(4);
		$display("test clksel done");
	endtask

	task automatic t_run(logic [3:0] n);
		int i, lows, seen;
		@(posedge clock);
		err_frames <= n;
		selftest_enable_pin <= 1;
		for (i = 0; i < 4 && !remote_selftest_start; i++) tick(1);
		chk("start cmd", 1, remote_selftest_start);
		for (i = 0; i < 40 && pass_o !== 1'b1; i++) tick(1);
		chk("pass high", 1, pass_o);
		lows = 0;
		for (i = 0; i < 40; i++) begin
			tick(1);
			lows += (pass_o === 1'b0);
		end
		chk("err pulses", n, lows);
		rd(8'h25, d);
		chk("count", n, d);
		@(posedge clock);
		selftest_enable_pin <= 0;
		tick(2);
		chk("result", n == 4'h0, pass_o);
		tick(1);
		chk("result end", 0, pass_o);
		tick(5);
		chk("stopped", 0, {remote_selftest_start, selftest_active});
		seen = 0;
		for (i = 0; i < 6; i++) begin
			tick(1);
			seen += (pass_o === 1'b1);
		end
		chk("pass not held", 0, seen);
		rd(8'h25, d);
		chk("count kept", n, d);
		$display("test run done");
	endtask

	task automatic results;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		t_states();
		t_clksel();
		t_run(4'h2);
		t_run(4'h0);
		results();
	end

	// whole run is well under a thousand cycles
	initial begin
		#(20 * 5000);
		failures++;
		results();
	end
endmodule
